/* File: lcdmc_chk.sv */
/*
 * Checker for the LCD mode command interpreter.
 * Assumes: bound into lcdmc_top, whose port names it shares.
 */
module lcdmc_chk
    import lcdmc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic COMMAND_DATA_SELECT,
    input wire logic [LCDMC_DATA_W-1:0] WDATA,
    input wire logic DRIVE_CLK,
    input wire logic OSC_OUT,
    input wire logic OSC_OUT_OE,
    input wire logic DRIVE_ACTIVE,
    input wire logic DRIVERS_AT_VDD,
    input wire logic POWER_SAVE,
    input wire logic RMW_ACTIVE,
    input wire logic DISPLAY_ON,
    input wire logic STATIC_DRIVE,
    input wire logic ALL_COM_SELECT,
    input wire logic [LCDMC_COL_W-1:0] COLUMN_ADDR,
    input wire logic [LCDMC_PAGE_W-1:0] PAGE_ADDR,
    input wire logic [LCDMC_LINE_W-1:0] START_LINE
);
    // ----
    // Command decode and saved column
    // ----
    wire logic wc = WR_STB && !COMMAND_DATA_SELECT;
    wire logic ent = wc && WDATA == LCDMC_CMD_RMW;
    wire logic fin = wc && WDATA == LCDMC_CMD_END;
    wire logic stc = wc && (WDATA & LCDMC_MASK_STATIC) == LCDMC_CMD_STATIC;
    wire logic off = WDATA == LCDMC_CMD_STATIC;
    wire logic don = WDATA == (LCDMC_CMD_DISP | 8'h_01);
    logic [LCDMC_COL_W-1:0] sav_q;
    wire logic [LCDMC_COL_W-1:0] sav_d =
        (ent && !RMW_ACTIVE) ? COLUMN_ADDR : sav_q;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) sav_q <= LCDMC_COL_RST;
        else sav_q <= sav_d;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    chk_rmw_enter: assert property (ent |=> RMW_ACTIVE)
        else $error("rmw mode not entered");
    chk_rmw_read: assert property (RMW_ACTIVE && RD_STB
        && COMMAND_DATA_SELECT |=> $stable(COLUMN_ADDR))
        else $error("column moved on rmw read");
    chk_end_restore: assert property (fin && RMW_ACTIVE
        |=> !RMW_ACTIVE && COLUMN_ADDR == sav_q)
        else $error("end did not restore column");
    chk_end_idle: assert property (fin && !RMW_ACTIVE
        |=> $stable(COLUMN_ADDR))
        else $error("idle end moved column");
    chk_swrst_regs: assert property (wc && WDATA == LCDMC_CMD_SWRST
        |=> START_LINE == LCDMC_LINE_RST
        && PAGE_ADDR == LCDMC_PAGE_SWRST)
        else $error("soft reset values wrong");
    chk_static_set: assert property (stc
        |=> STATIC_DRIVE == $past(WDATA[0]))
        else $error("static drive not set");
    chk_ps_enter: assert property (stc && WDATA[0] && !DISPLAY_ON
        |=> POWER_SAVE)
        else $error("power save not entered");
    chk_ps_drive: assert property (POWER_SAVE
        |-> !DRIVE_ACTIVE && DRIVERS_AT_VDD && !ALL_COM_SELECT)
        else $error("drivers active in power save");
    chk_ps_osc: assert property (POWER_SAVE |-> !OSC_OUT_OE)
        else $error("oscillator output driven");
    chk_ps_quiet: assert property (POWER_SAVE
        |=> !DRIVE_CLK && !OSC_OUT)
        else $error("drive clock running in power save");
    chk_ps_keep: assert property (POWER_SAVE && !WR_STB && !RD_STB
        |=> $stable({START_LINE, PAGE_ADDR, COLUMN_ADDR, RMW_ACTIVE}))
        else $error("settings lost in power save");
    chk_ps_exit: assert property (POWER_SAVE && wc && (off || don)
        |=> !POWER_SAVE)
        else $error("power save not left");
    cov_ps: cover property (POWER_SAVE ##1 !POWER_SAVE);
    cov_end: cover property (fin && RMW_ACTIVE);
    cov_swrst: cover property (wc && WDATA == LCDMC_CMD_SWRST);
endmodule // lcdmc_chk

bind lcdmc_top lcdmc_chk i_chk (.*);

/* File: lcdmc_host.sv */
/*
 * Host processor model for the parallel command/data port.
 * Assumes: requests taken on the rising clock edge, one per cycle.
 */
module lcdmc_host (
    input wire logic clk,
    output logic wr_stb,
    output logic rd_stb,
    output logic sel,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        sel = 1'b0;
        wdata = 8'h_00;
    end
    // Released lines flip so stale values never look valid
    task automatic wr(input logic s, input logic [7:0] b);
        @(negedge clk);
        sel <= s;
        wdata <= b;
        wr_stb <= 1'b1;
        @(negedge clk);
        wr_stb <= 1'b0;
        wdata <= ~b;
        sel <= ~s;
    endtask
    task automatic rd();
        @(negedge clk);
        sel <= 1'b1;
        rd_stb <= 1'b1;
        @(negedge clk);
        rd_stb <= 1'b0;
        sel <= 1'b0;
        wdata <= ~wdata;
    endtask
endmodule // lcdmc_host

/* File: lcdmc_pkg.sv */
/*
 * Constants shared by the LCD mode command interpreter: command codes,
 * field masks, reset values and address widths.
 * Assumes: included before all other design files of the block.
 */
package lcdmc_pkg;

    localparam int LCDMC_COL_W = 7;
    localparam int LCDMC_PAGE_W = 2;
    localparam int LCDMC_LINE_W = 5;
    localparam int LCDMC_DATA_W = 8;

    localparam logic [7:0] LCDMC_CMD_RMW = 8'h_E0;
    localparam logic [7:0] LCDMC_CMD_END = 8'h_EE;
    localparam logic [7:0] LCDMC_CMD_SWRST = 8'h_E2;
    localparam logic [7:0] LCDMC_CMD_STATIC = 8'h_A4;
    localparam logic [7:0] LCDMC_MASK_STATIC = 8'h_FE;
    localparam logic [7:0] LCDMC_CMD_DISP = 8'h_AE;
    localparam logic [7:0] LCDMC_MASK_DISP = 8'h_FE;
    localparam logic [7:0] LCDMC_CMD_LINE = 8'h_C0;
    localparam logic [7:0] LCDMC_MASK_LINE = 8'h_E0;
    localparam logic [7:0] LCDMC_CMD_PAGE = 8'h_B8;
    localparam logic [7:0] LCDMC_MASK_PAGE = 8'h_FC;
    localparam logic [7:0] LCDMC_CMD_COL = 8'h_00;
    localparam logic [7:0] LCDMC_MASK_COL = 8'h_80;

    localparam logic [LCDMC_COL_W-1:0] LCDMC_COL_LAST = 7'h_4F;
    localparam logic [LCDMC_COL_W-1:0] LCDMC_COL_ONE = 7'h_01;
    localparam logic [LCDMC_COL_W-1:0] LCDMC_COL_RST = 7'h_00;
    localparam logic [LCDMC_PAGE_W-1:0] LCDMC_PAGE_SWRST = 2'h_3;
    localparam logic [LCDMC_PAGE_W-1:0] LCDMC_PAGE_RST = 2'h_0;
    localparam logic [LCDMC_LINE_W-1:0] LCDMC_LINE_RST = 5'h_00;

    typedef enum logic [0:0] {
        LCDMC_ST_NORMAL = 1'b0,
        LCDMC_ST_RMW = 1'b1
    } lcdmc_state_t;

endpackage

/* File: lcdmc_ram.sv */
/*
 * Display data memory, four pages of columns, registered read port.
 * Assumes: one write or read per cycle, addresses in range.
 */
module lcdmc_ram
    import lcdmc_pkg::*;
#(
    parameter int COLS = 80
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [LCDMC_PAGE_W-1:0] page,
    input wire logic [LCDMC_COL_W-1:0] col,
    input wire logic [LCDMC_DATA_W-1:0] wdata,
    output logic [LCDMC_DATA_W-1:0] rdata
);
    localparam int DEPTH = COLS << LCDMC_PAGE_W;

    logic [LCDMC_DATA_W-1:0] mem [DEPTH];
    logic [LCDMC_DATA_W-1:0] rdata_q;
    wire [31:0] addr = 32'(page) * 32'(COLS) + 32'(col);

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end

    assign rdata = rdata_q;
endmodule // lcdmc_ram

/* File: lcdmc_sync.sv */
/*
 * Two flip-flop synchroniser for a bundle of level signals.
 * Assumes: inputs come from outside the CLK_SYS domain.
 */
module lcdmc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule // lcdmc_sync

/* File: lcdmc_top.sv */
/*
 * LCD driver mode command interpreter: read-modify-write mode with its
 * end command, software reset, static drive, display on/off and the
 * power-save state, plus address registers and display data memory.
 * Assumes: host strobes are synchronous single-cycle pulses on CLK_SYS;
 * the hardware reset pin is NRST, driven by the host at power-up.
 */
module lcdmc_top
    import lcdmc_pkg::*;
#(
    parameter int COLS = 80
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic COMMAND_DATA_SELECT,
    input wire logic [LCDMC_DATA_W-1:0] WDATA,
    output logic [LCDMC_DATA_W-1:0] RDATA,
    input wire logic EXT_CLK,
    output logic DRIVE_CLK,
    output logic OSC_OUT,
    output logic OSC_OUT_OE,
    output logic DRIVE_ACTIVE,
    output logic DRIVERS_AT_VDD,
    output logic POWER_SAVE,
    output logic RMW_ACTIVE,
    output logic DISPLAY_ON,
    output logic STATIC_DRIVE,
    output logic ALL_COM_SELECT,
    output logic [LCDMC_COL_W-1:0] COLUMN_ADDR,
    output logic [LCDMC_PAGE_W-1:0] PAGE_ADDR,
    output logic [LCDMC_LINE_W-1:0] START_LINE
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic cmd_match(input logic [7:0] b,
                                       input logic [7:0] code,
                                       input logic [7:0] mask);
        return (b & mask) == (code & mask);
    endfunction

    function automatic logic [LCDMC_COL_W-1:0] col_step(
            input logic [LCDMC_COL_W-1:0] c);
        return (c >= LCDMC_COL_LAST) ? c : c + LCDMC_COL_ONE;
    endfunction

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire cmd_wr = WR_STB && !COMMAND_DATA_SELECT;
    wire dat_wr = WR_STB && COMMAND_DATA_SELECT;
    wire dat_rd = RD_STB && COMMAND_DATA_SELECT;

    wire is_rmw = cmd_wr && (WDATA == LCDMC_CMD_RMW);
    wire is_end = cmd_wr && (WDATA == LCDMC_CMD_END);
    wire is_swrst = cmd_wr && (WDATA == LCDMC_CMD_SWRST);
    wire is_static = cmd_wr &&
        cmd_match(WDATA, LCDMC_CMD_STATIC, LCDMC_MASK_STATIC);
    wire is_disp = cmd_wr &&
        cmd_match(WDATA, LCDMC_CMD_DISP, LCDMC_MASK_DISP);
    wire is_line = cmd_wr &&
        cmd_match(WDATA, LCDMC_CMD_LINE, LCDMC_MASK_LINE);
    wire is_page = cmd_wr &&
        cmd_match(WDATA, LCDMC_CMD_PAGE, LCDMC_MASK_PAGE);
    wire is_col = cmd_wr &&
        cmd_match(WDATA, LCDMC_CMD_COL, LCDMC_MASK_COL);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lcdmc_state_t state_q, state_d;
    logic [LCDMC_COL_W-1:0] col_q, col_d;
    logic [LCDMC_COL_W-1:0] saved_col_q, saved_col_d;
    logic [LCDMC_PAGE_W-1:0] page_q, page_d;
    logic [LCDMC_LINE_W-1:0] line_q, line_d;
    logic static_q, static_d;
    logic disp_q, disp_d;
    logic [LCDMC_DATA_W-1:0] rdata_q, rdata_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            LCDMC_ST_NORMAL: begin
                if (is_rmw) begin
                    state_d = LCDMC_ST_RMW;
                end
            end
            LCDMC_ST_RMW: begin
                if (is_end) begin
                    state_d = LCDMC_ST_NORMAL;
                end
            end
            default: state_d = LCDMC_ST_NORMAL;
        endcase
    end

    wire in_rmw = (state_q == LCDMC_ST_RMW);

    // Save column only on mode entry
    assign saved_col_d = (is_rmw && !in_rmw) ? col_q : saved_col_q;

    always_comb begin
        col_d = col_q;
        if (is_end && in_rmw) begin
            col_d = saved_col_q;
        end else if (is_end) begin
            col_d = col_q;
        end else if (is_col) begin
            col_d = WDATA[LCDMC_COL_W-1:0];
        end else if (dat_wr) begin
            col_d = col_step(col_q);
        end else if (dat_rd && !in_rmw) begin
            col_d = col_step(col_q);
        end
    end

    // Software reset touches only line and page, never memory
    assign line_d = is_swrst ? LCDMC_LINE_RST :
        (is_line ? WDATA[LCDMC_LINE_W-1:0] : line_q);
    assign page_d = is_swrst ? LCDMC_PAGE_SWRST :
        (is_page ? WDATA[LCDMC_PAGE_W-1:0] : page_q);
    assign static_d = is_static ? WDATA[0] : static_q;
    assign disp_d = is_disp ? WDATA[0] : disp_q;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_q <= LCDMC_ST_NORMAL;
            col_q <= LCDMC_COL_RST;
            saved_col_q <= LCDMC_COL_RST;
            page_q <= LCDMC_PAGE_RST;
            line_q <= LCDMC_LINE_RST;
            static_q <= 1'b0;
            disp_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            state_q <= state_d;
            col_q <= col_d;
            saved_col_q <= saved_col_d;
            page_q <= page_d;
            line_q <= line_d;
            static_q <= static_d;
            disp_q <= disp_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Display memory
    // ----------------------------------------------------------------
    logic [LCDMC_DATA_W-1:0] ram_rdata;

    // Only data writes reach memory; software reset has no path here
    lcdmc_ram #(
        .COLS(COLS)
    ) u_ram (
        .clk(CLK_SYS),
        .we(dat_wr),
        .page(page_q),
        .col(col_q),
        .wdata(WDATA),
        .rdata(ram_rdata)
    );

    // Read latch: RDATA holds the word fetched on the last read, so no dummy read
    assign rdata_d = dat_rd ? ram_rdata : rdata_q;
    assign RDATA = rdata_q;

    // ----------------------------------------------------------------
    // Power save
    // ----------------------------------------------------------------
    // Mode settings stay in their registers across power save
    wire psave = static_q && !disp_q;

    logic ext_clk_s;
    lcdmc_sync #(
        .W(1)
    ) u_sync (
        .clk(CLK_SYS),
        .rst_n(NRST),
        .async_in(EXT_CLK),
        .sync_out(ext_clk_s)
    );

    logic osc_q;
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= psave ? 1'b0 : ext_clk_s;
        end
    end

    assign DRIVE_CLK = osc_q;
    assign OSC_OUT = osc_q;
    assign OSC_OUT_OE = !psave;
    assign DRIVE_ACTIVE = !psave;
    assign DRIVERS_AT_VDD = psave;
    assign POWER_SAVE = psave;
    assign RMW_ACTIVE = in_rmw;
    assign DISPLAY_ON = (disp_q || static_q) && !psave;
    assign STATIC_DRIVE = static_q;
    assign ALL_COM_SELECT = static_q && !psave;
    assign COLUMN_ADDR = col_q;
    assign PAGE_ADDR = page_q;
    assign START_LINE = line_q;
endmodule // lcdmc_top

/* File: testbench.sv */
/*
 * Self-checking bench for lcdmc_top with the host model.
 * Assumes: lcdmc_chk is bound; inputs change on the falling edge.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import lcdmc_pkg::*;
    logic CLK_SYS = 1'b0, NRST = 1'b0, EXT_CLK = 1'b0;
    logic WR_STB, RD_STB, COMMAND_DATA_SELECT, DRIVE_CLK, OSC_OUT, OSC_OUT_OE;
    logic DRIVE_ACTIVE, DRIVERS_AT_VDD, POWER_SAVE, RMW_ACTIVE, DISPLAY_ON;
    logic STATIC_DRIVE, ALL_COM_SELECT;
    logic [7:0] WDATA, RDATA, c, d, p, l;
    logic [6:0] COLUMN_ADDR;
    logic [1:0] PAGE_ADDR;
    logic [4:0] START_LINE;
    int bad_count = 0, num_checks = 0, seed = 32'h45fe40a9;
    always #20 CLK_SYS = ~CLK_SYS;
    always @(negedge CLK_SYS) EXT_CLK <= ~EXT_CLK;
    lcdmc_host i_host (.clk(CLK_SYS), .wr_stb(WR_STB), .rd_stb(RD_STB),
        .sel(COMMAND_DATA_SELECT), .wdata(WDATA));
    lcdmc_top i_dut (.*);
    // ----
    // Compare, expectation and closing helpers
    // ----
    task automatic chkv(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chkv({7'h_00, g}, {7'h_00, e});
    endtask
    function automatic logic [7:0] nxt(input logic [7:0] a);
        return (a == 8'(LCDMC_COL_LAST)) ? a : a + 8'h_01;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge CLK_SYS);
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        NRST = 1'b1;
        chkv(8'(COLUMN_ADDR), 8'h_00);
        chkv(8'(PAGE_ADDR), 8'h_00);
        chkb(OSC_OUT_OE, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 8'(LCDMC_COL_LAST)
                : 8'($unsigned($random(seed)) % 80);
            d = 8'($random(seed));
            p = 8'($unsigned($random(seed)) % 4);
            l = 8'($unsigned($random(seed)) % 32);
            i_host.wr(1'b0, LCDMC_CMD_PAGE | p);
            i_host.wr(1'b0, c);
            i_host.wr(1'b1, d);
            i_host.wr(1'b0, c);
            i_host.wr(1'b0, LCDMC_CMD_RMW);
            chkb(RMW_ACTIVE, 1'b1);
            i_host.rd();
            chkv(RDATA, d);
            chkv(8'(COLUMN_ADDR), c);
            i_host.wr(1'b1, ~d);
            chkv(8'(COLUMN_ADDR), nxt(c));
            i_host.wr(1'b0, LCDMC_CMD_END);
            chkb(RMW_ACTIVE, 1'b0);
            chkv(8'(COLUMN_ADDR), c);
            i_host.wr(1'b0, LCDMC_CMD_END);
            chkv(8'(COLUMN_ADDR), c);
            i_host.wr(1'b0, LCDMC_CMD_LINE | l);
            i_host.wr(1'b0, LCDMC_CMD_SWRST);
            chkv(8'(START_LINE), 8'h_00);
            chkv(8'(PAGE_ADDR), 8'h_03);
            i_host.wr(1'b0, LCDMC_CMD_PAGE | p);
            i_host.wr(1'b0, c);
            i_host.rd();
            chkv(RDATA, ~d);
            i_host.wr(1'b0, LCDMC_CMD_LINE | l);
            i_host.wr(1'b0, LCDMC_CMD_DISP);
            i_host.wr(1'b0, LCDMC_CMD_STATIC | 8'h_01);
            chkb(POWER_SAVE, 1'b1);
            chkb(DRIVE_ACTIVE, 1'b0);
            chkb(DRIVERS_AT_VDD, 1'b1);
            chkb(OSC_OUT_OE, 1'b0);
            repeat (2) begin
                @(negedge CLK_SYS);
                chkb(DRIVE_CLK, 1'b0);
                chkb(OSC_OUT, 1'b0);
            end
            i_host.wr(1'b0,
                i[0] ? (LCDMC_CMD_DISP | 8'h_01) : LCDMC_CMD_STATIC);
            chkb(POWER_SAVE, 1'b0);
            chkb(DRIVE_ACTIVE, 1'b1);
            chkb(DISPLAY_ON, i[0]);
            chkb(ALL_COM_SELECT, i[0]);
            chkv(8'(START_LINE), l);
            chkv(8'(PAGE_ADDR), p);
            i_host.wr(1'b0, LCDMC_CMD_STATIC);
            $display("test iteration %0d done", i);
        end
        // Reset in mid-run while in power save and rmw mode
        i_host.wr(1'b0, LCDMC_CMD_DISP);
        i_host.wr(1'b0, LCDMC_CMD_STATIC | 8'h_01);
        i_host.wr(1'b0, LCDMC_CMD_RMW);
        NRST = 1'b0;
        @(negedge CLK_SYS);
        NRST = 1'b1;
        chkb(POWER_SAVE, 1'b0);
        chkb(RMW_ACTIVE, 1'b0);
        chkb(OSC_OUT_OE, 1'b1);
        chkv(8'(PAGE_ADDR), 8'h_00);
        $display("test mid reset done");
        end_sim();
    end
endmodule // testbench
